// ### ebt_pkg.sv
// Constants, field layouts and carrier types of the 8/16-bit base timer
`default_nettype none

package ebt_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_COUNT_LOW   = 12'h19c;
    localparam logic [ADDR_W-1:0] OFS_PERIOD_HIGH = 12'h19d;
    localparam logic [ADDR_W-1:0] OFS_CTRL_A      = 12'h19e;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B      = 12'h19f;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTLA_EN_BIT    = 7;
    localparam int CTLA_OUT_BIT   = 5;
    localparam int CTLA_WIDTH_BIT = 4;
    localparam int CTLA_POST_LSB  = 0;
    localparam int POST_W         = 4;
    localparam int CTLB_CS_LSB    = 5;
    localparam int CS_W           = 3;
    localparam int CTLB_UNSYNCED_INPUT_BIT_BIT = 4;
    localparam int CTLB_PRE_LSB   = 0;
    localparam int PRE_W          = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_COUNT_LOW   = 8'h00;
    localparam logic [DATA_W-1:0] RST_PERIOD_HIGH = 8'hff;
    localparam logic [DATA_W-1:0] RST_CTRL_A      = 8'h00;
    localparam logic [DATA_W-1:0] RST_CTRL_B      = 8'h00;

    // ------------------------------------------------------------------
    // Clock sources and prescaler
    // ------------------------------------------------------------------
    localparam int EXT_SRC_N = 5;
    localparam int SYNC_N    = EXT_SRC_N + 1;
    localparam int PRE_CNT_W = 15;

    typedef enum logic [CS_W-1:0] {
        CS_PIN     = 3'h0,
        CS_PIN_INV = 3'h1,
        CS_INSTR   = 3'h2,
        CS_EXT0    = 3'h3,
        CS_EXT1    = 3'h4,
        CS_EXT2    = 3'h5,
        CS_EXT3    = 3'h6,
        CS_EXT4    = 3'h7
    } ebt_csel_e;

    typedef struct packed {
        logic               en;
        logic               width16;
        logic [POST_W-1:0]  postSel;
        logic [CS_W-1:0]    clkSel;
        logic               unsync;
        logic [PRE_W-1:0]   preSel;
    } ebt_ctrl_s;

    // Low bits that must all be set before a prescaled tick leaves
    function automatic logic [PRE_CNT_W-1:0] ebt_pre_mask(
        input logic [PRE_W-1:0] sel);
        logic [PRE_CNT_W-1:0] m;
        m = '0;
        for (int i = 0; i < PRE_CNT_W; i++) begin
            m[i] = (i < int'(sel));
        end
        return m;
    endfunction

endpackage

`default_nettype wire

// ### ebt_clk_src.sv
// Counting clock source selection, synchronisation and edge detection
`default_nettype none

module ebt_clk_src
    import ebt_pkg::*;
(
    input  wire logic                 sys_clk,    // System clock
    input  wire logic                 nrst,       // Sync reset, active low
    input  wire logic                 pinIn,      // Timer clock pin
    input  wire logic [EXT_SRC_N-1:0] extClk,     // Other clock sources
    input  wire logic [CS_W-1:0]      clkSel,     // Source select code
    output logic                      srcTick     // One pulse per rising edge, high every cycle for CS_INSTR
);

    typedef struct packed {
        logic [SYNC_N-1:0] meta;
        logic [SYNC_N-1:0] sync;
        logic              selLvl;
        logic              tick;
    } ebt_src_s;

    ebt_src_s state_ff;
    ebt_src_s nxt_state;
    logic     curLvl;

    // ------------------------------------------------------------------
    // Source multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        case (ebt_csel_e'(clkSel))
            CS_PIN:     curLvl = state_ff.sync[0];
            CS_PIN_INV: curLvl = ~state_ff.sync[0];
            CS_INSTR:   curLvl = 1'b1;
            default:    curLvl = state_ff.sync[clkSel - 3'h2];
        endcase
    end

    always_comb begin
        nxt_state        = state_ff;
        nxt_state.meta   = {extClk, pinIn};
        nxt_state.sync   = state_ff.meta;
        nxt_state.selLvl = curLvl;
        if (ebt_csel_e'(clkSel) == CS_INSTR) begin
            nxt_state.tick = 1'b1;
        end else begin
            nxt_state.tick = curLvl & ~state_ff.selLvl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign srcTick = state_ff.tick;

endmodule // ebt_clk_src

`default_nettype wire

// ### ebt_prescaler.sv
// Input prescaler of the base timer, sixteen power-of-two ratios
`default_nettype none

module ebt_prescaler
    import ebt_pkg::*;
(
    input  wire logic             sys_clk,   // System clock
    input  wire logic             nrst,      // Sync reset, active low
    input  wire logic             clear,     // Clear the divider count
    input  wire logic             enable,    // Count permitted
    input  wire logic [PRE_W-1:0] preSel,    // Ratio code n gives 1:2^n
    input  wire logic             inTick,    // Undivided source tick
    output logic                  outTick    // Divided tick pulse
);

    typedef struct packed {
        logic [PRE_CNT_W-1:0] cnt;
        logic                 tick;
    } ebt_pre_s;

    ebt_pre_s             state_ff;
    ebt_pre_s             nxt_state;
    logic [PRE_CNT_W-1:0] mask;

    always_comb begin
        mask           = ebt_pre_mask(preSel);
        nxt_state      = state_ff;
        nxt_state.tick = 1'b0;
        if (clear) begin
            nxt_state.cnt = '0;
        end else if (enable && inTick) begin
            nxt_state.tick = ((state_ff.cnt & mask) == mask);
            nxt_state.cnt  = state_ff.cnt + 15'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign outTick = state_ff.tick;

endmodule // ebt_prescaler

`default_nettype wire

// ### ebt_timer.sv
// Top of the 8/16-bit base timer: registers, counter and postscaler
//
// What this block does
// R1: Counts as 8-bit or 16-bit per width select.
// R2: Count advances on prescaled rising source edges.
// R3: 8-bit: low byte cleared on period-buffer match.
// R4: Each match reloads period buffer from register.
// R5: 16-bit: low read captures high count byte.
// R6: 16-bit: low write also loads high byte.
// R7: 16-bit count wraps from maximum to zero.
// R8: Count writes ignored while running 16-bit.
// R9: Clock source select field picks counting clock.
// R10: Synchronised mode aligns ticks to instruction clock.
// R11: Synchronised mode stops counting during sleep.
// R12: Unsynchronised mode counts every prescaled source edge.
// R13: Unsynchronised mode keeps counting through sleep.
// R14: Prescaler offers sixteen ratios, count hidden.
// R15: Prescaler cleared by count, control writes, reset.
// R16: Postscaler divides output events one to sixteen.
// R17: Postscaler cleared by count, control writes, reset.
// R18: Output toggles per postscaled match or rollover.
// R19: Interrupt flag set whenever output toggles.
// R20: Prescale code n divides by two power n.
// R21: Codes: 010 instruction, 000 pin, 001 inverted.
// R22: Disabled timer holds count, scalers, no events.
`default_nettype none

module ebt_timer
    import ebt_pkg::*;
(
    input  wire logic                 sys_clk,        // 25 MHz clock
    input  wire logic                 nrst,           // Sync reset, low
    input  wire logic [ADDR_W-1:0]    busAddr,        // Register address
    input  wire logic [DATA_W-1:0]    busWrData,      // Write data
    input  wire logic                 busWrStrobe,    // Write strobe
    input  wire logic                 busRdStrobe,    // Read strobe
    output logic      [DATA_W-1:0]    busRdData,      // Read data, next cycle
    input  wire logic                 tmrPinIn,       // Clock input pin
    input  wire logic [EXT_SRC_N-1:0] extSrcClk,      // Other clock sources
    input  wire logic                 sleepMode,      // Device in sleep
    output logic                      timerToggleOut, // Timer output level
    output logic                      timerIrqFlag    // Flag set pulse
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ebt_ctrl_s          ctrl;
        logic               outLvl;
        logic [DATA_W-1:0]  countLow;
        logic [DATA_W-1:0]  countHigh;
        logic [DATA_W-1:0]  periodHigh;
        logic [DATA_W-1:0]  periodBuf;
        logic [POST_W-1:0]  postCnt;
        logic               syncTick;
        logic               irqPulse;
        logic [DATA_W-1:0]  rdData;
    } ebt_top_s;

    localparam ebt_ctrl_s RST_CTRL = '{
        en:      RST_CTRL_A[CTLA_EN_BIT],
        width16: RST_CTRL_A[CTLA_WIDTH_BIT],
        postSel: RST_CTRL_A[CTLA_POST_LSB +: POST_W],
        clkSel:  RST_CTRL_B[CTLB_CS_LSB +: CS_W],
        unsync:  RST_CTRL_B[CTLB_UNSYNCED_INPUT_BIT_BIT],
        preSel:  RST_CTRL_B[CTLB_PRE_LSB +: PRE_W]
    };

    ebt_top_s state_ff;
    ebt_top_s nxt_state;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic wrLow;
    logic wrHigh;
    logic wrCtrlA;
    logic wrCtrlB;
    logic rdLow;
    logic scalerClear;
    logic runEnable;
    logic srcTick;
    logic preTick;
    logic cntTick;
    logic cntEvent;
    logic [2*DATA_W-1:0] count16;
    logic [2*DATA_W-1:0] count16Inc;

    assign wrLow   = busWrStrobe && (busAddr == OFS_COUNT_LOW);
    assign wrHigh  = busWrStrobe && (busAddr == OFS_PERIOD_HIGH);
    assign wrCtrlA = busWrStrobe && (busAddr == OFS_CTRL_A);
    assign wrCtrlB = busWrStrobe && (busAddr == OFS_CTRL_B);
    assign rdLow   = busRdStrobe && (busAddr == OFS_COUNT_LOW);

    // Scalers lose their partial count on any of these writes
    assign scalerClear = wrLow || wrCtrlA || wrCtrlB; // R15 R17

    // Synchronised mode has no clock in sleep; unsynchronised keeps going
    assign runEnable = state_ff.ctrl.en
                       && (state_ff.ctrl.unsync || !sleepMode); // R11 R13 R22

    // ------------------------------------------------------------------
    // Clock path
    // ------------------------------------------------------------------
    ebt_clk_src u_clk_src (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pinIn   (tmrPinIn),
        .extClk  (extSrcClk),
        .clkSel  (state_ff.ctrl.clkSel),
        .srcTick (srcTick)
    ); // R9 R21

    ebt_prescaler u_prescaler (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clear   (scalerClear),
        .enable  (runEnable),
        .preSel  (state_ff.ctrl.preSel),
        .inTick  (srcTick),
        .outTick (preTick)
    ); // R2 R14 R20

    // Synchronised ticks take one extra stage on the instruction clock
    always_comb begin
        if (state_ff.ctrl.unsync) begin
            cntTick = preTick && runEnable; // R12
        end else begin
            cntTick = state_ff.syncTick && runEnable; // R10
        end
    end

    assign count16    = {state_ff.countHigh, state_ff.countLow};
    assign count16Inc = count16 + 16'h0001;

    // ------------------------------------------------------------------
    // Count event (match or rollover)
    // ------------------------------------------------------------------
    always_comb begin
        if (!cntTick) begin
            cntEvent = 1'b0;
        end else if (state_ff.ctrl.width16) begin
            cntEvent = (count16 == 16'hffff); // R7
        end else begin
            cntEvent = (state_ff.countLow == state_ff.periodBuf); // R3
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state          = state_ff;
        nxt_state.irqPulse = 1'b0;
        nxt_state.rdData   = 8'h00;
        nxt_state.syncTick = preTick && runEnable && !state_ff.ctrl.unsync;

        // Counter
        if (cntTick) begin
            if (state_ff.ctrl.width16) begin
                nxt_state.countLow  = count16Inc[DATA_W-1:0]; // R1 R7
                nxt_state.countHigh = count16Inc[2*DATA_W-1:DATA_W];
            end else if (cntEvent) begin
                nxt_state.countLow  = 8'h00; // R3
                nxt_state.periodBuf = state_ff.periodHigh; // R4
            end else begin
                nxt_state.countLow = state_ff.countLow + 8'h01; // R1
            end
        end

        // In 8-bit mode the idle buffer follows the period register so a fresh start uses it
        if (!state_ff.ctrl.en && !state_ff.ctrl.width16) begin
            nxt_state.periodBuf = state_ff.periodHigh;
        end

        // Postscaler and output
        if (scalerClear) begin
            nxt_state.postCnt = 4'h0; // R17
        end else if (cntEvent) begin
            if (state_ff.postCnt == state_ff.ctrl.postSel) begin
                nxt_state.postCnt  = 4'h0; // R16
                nxt_state.outLvl   = ~state_ff.outLvl; // R18
                nxt_state.irqPulse = 1'b1; // R19
            end else begin
                nxt_state.postCnt = state_ff.postCnt + 4'h1; // R16
            end
        end

        // Register writes
        if (wrLow) begin
            if (!state_ff.ctrl.width16) begin
                nxt_state.countLow = busWrData;
            end else if (!state_ff.ctrl.en) begin
                nxt_state.countLow  = busWrData; // R6 R8
                nxt_state.countHigh = state_ff.periodHigh; // R6
            end
        end
        if (wrHigh) begin
            nxt_state.periodHigh = busWrData;
        end
        if (wrCtrlA) begin
            nxt_state.ctrl.en      = busWrData[CTLA_EN_BIT];
            nxt_state.ctrl.width16 = busWrData[CTLA_WIDTH_BIT];
            nxt_state.ctrl.postSel = busWrData[CTLA_POST_LSB +: POST_W];
        end
        if (wrCtrlB) begin
            nxt_state.ctrl.clkSel = busWrData[CTLB_CS_LSB +: CS_W];
            nxt_state.ctrl.unsync = busWrData[CTLB_UNSYNCED_INPUT_BIT_BIT];
            nxt_state.ctrl.preSel = busWrData[CTLB_PRE_LSB +: PRE_W];
        end
        if (scalerClear) begin
            nxt_state.syncTick = 1'b0; // R15
        end

        // Register reads
        if (busRdStrobe) begin
            case (busAddr)
                OFS_COUNT_LOW: begin
                    nxt_state.rdData = state_ff.countLow;
                end
                OFS_PERIOD_HIGH: begin
                    nxt_state.rdData = state_ff.periodHigh;
                end
                OFS_CTRL_A: begin
                    nxt_state.rdData[CTLA_EN_BIT]    = state_ff.ctrl.en;
                    nxt_state.rdData[CTLA_OUT_BIT]   = state_ff.outLvl;
                    nxt_state.rdData[CTLA_WIDTH_BIT] = state_ff.ctrl.width16;
                    nxt_state.rdData[CTLA_POST_LSB +: POST_W] =
                        state_ff.ctrl.postSel;
                end
                OFS_CTRL_B: begin
                    nxt_state.rdData[CTLB_CS_LSB +: CS_W] =
                        state_ff.ctrl.clkSel;
                    nxt_state.rdData[CTLB_UNSYNCED_INPUT_BIT_BIT] = state_ff.ctrl.unsync;
                    nxt_state.rdData[CTLB_PRE_LSB +: PRE_W] =
                        state_ff.ctrl.preSel;
                end
                default: begin
                    nxt_state.rdData = 8'h00;
                end
            endcase
        end

        // Low read latches the live high byte for a coherent 16-bit pair
        if (rdLow && state_ff.ctrl.width16) begin
            nxt_state.periodHigh = state_ff.countHigh; // R5
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_ff.ctrl       <= RST_CTRL;
            state_ff.outLvl     <= 1'b0;
            state_ff.countLow   <= RST_COUNT_LOW;
            state_ff.countHigh  <= 8'h00;
            state_ff.periodHigh <= RST_PERIOD_HIGH;
            state_ff.periodBuf  <= RST_PERIOD_HIGH;
            state_ff.postCnt    <= 4'h0; // R17
            state_ff.syncTick   <= 1'b0;
            state_ff.irqPulse   <= 1'b0;
            state_ff.rdData     <= 8'h00;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign busRdData      = state_ff.rdData;
    assign timerToggleOut = state_ff.outLvl;
    assign timerIrqFlag   = state_ff.irqPulse;

endmodule // ebt_timer

`default_nettype wire

// ### ebt_timer_sva.sv
// Concurrent assertions of the base timer, bound to its top module
`default_nettype none

module ebt_timer_chk
    import ebt_pkg::*;
(
    input wire logic              sys_clk,        // Clock
    input wire logic              nrst,           // Reset, low
    input wire logic [ADDR_W-1:0] busAddr,        // Address
    input wire logic [DATA_W-1:0] busWrData,      // Write data
    input wire logic              busWrStrobe,    // Write strobe
    input wire logic              busRdStrobe,    // Read strobe
    input wire logic [DATA_W-1:0] busRdData,      // Read data
    input wire logic              sleepMode,      // Sleep level
    input wire logic              timerToggleOut, // Output level
    input wire logic              timerIrqFlag    // Flag pulse
);
    // ------------------------------------------------------------------
    // Shadow of the software-written registers
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] ctrlA_ff;
    logic [DATA_W-1:0] ctrlB_ff;
    logic [DATA_W-1:0] period_ff;
    logic              periodOk_ff;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrlA_ff    <= RST_CTRL_A;
            ctrlB_ff    <= RST_CTRL_B;
            period_ff   <= RST_PERIOD_HIGH;
            periodOk_ff <= 1'b1;
        end else if (busWrStrobe && busAddr == OFS_CTRL_A) begin
            ctrlA_ff <= busWrData & 8'h9f;
        end else if (busWrStrobe && busAddr == OFS_CTRL_B) begin
            ctrlB_ff <= busWrData;
        end else if (busWrStrobe && busAddr == OFS_PERIOD_HIGH) begin
            period_ff   <= busWrData;
            periodOk_ff <= 1'b1;
        end else if (busRdStrobe && busAddr == OFS_COUNT_LOW &&
                     ctrlA_ff[CTLA_WIDTH_BIT]) begin
            periodOk_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    rd_idle_a: assert property (
        !busRdStrobe |=> busRdData == 8'h00)
        else $error("read data not idle");
    irq_toggle_a: assert property ($past(nrst) |->
        timerIrqFlag == (timerToggleOut != $past(timerToggleOut)))
        else $error("flag and toggle differ");
    idle_quiet_a: assert property (!ctrlA_ff[CTLA_EN_BIT] &&
        !$past(ctrlA_ff[CTLA_EN_BIT]) && !$past(ctrlA_ff[CTLA_EN_BIT], 2)
        |-> !timerIrqFlag && $stable(timerToggleOut))
        else $error("event while disabled");
    ctla_read_a: assert property (
        busRdStrobe && busAddr == OFS_CTRL_A |=> busRdData ==
        {ctrlA_ff[7], 1'b0, $past(timerToggleOut), ctrlA_ff[4:0]})
        else $error("ctrl a read");
    ctlb_read_a: assert property (
        busRdStrobe && busAddr == OFS_CTRL_B |=> busRdData == ctrlB_ff)
        else $error("ctrl b read");
    period_read_a: assert property (busRdStrobe &&
        busAddr == OFS_PERIOD_HIGH && periodOk_ff |=> busRdData == period_ff)
        else $error("period read");
    sleep_halt_a: assert property (sleepMode && $past(sleepMode) &&
        $past(sleepMode, 2) && !ctrlB_ff[CTLB_UNSYNCED_INPUT_BIT_BIT] &&
        !$past(ctrlB_ff[CTLB_UNSYNCED_INPUT_BIT_BIT], 2) |-> !timerIrqFlag)
        else $error("event in sleep");
    count_write_a: assert property (busWrStrobe &&
        busAddr == OFS_COUNT_LOW && !ctrlA_ff[CTLA_WIDTH_BIT] ##1
        busRdStrobe && busAddr == OFS_COUNT_LOW
        |=> busRdData == $past(busWrData, 2))
        else $error("count write lost");

endmodule // ebt_timer_chk

bind ebt_timer ebt_timer_chk u_ebt_timer_chk (.*);

`default_nettype wire

// ### ebt_timer_tb.sv
// Self-checking testbench of the 8/16-bit base timer
`default_nettype none

module testbench
    import ebt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                 sys_clk;
    logic                 nrst;
    logic [ADDR_W-1:0]    busAddr;
    logic [DATA_W-1:0]    busWrData;
    logic                 busWrStrobe;
    logic                 busRdStrobe;
    logic [DATA_W-1:0]    busRdData;
    logic                 tmrPinIn;
    logic [EXT_SRC_N-1:0] extSrcClk;
    logic                 sleepMode;
    logic                 timerToggleOut;
    logic                 timerIrqFlag;
    logic [15:0]          cycN = '0;
    logic [15:0]          lastIrq = '0;
    logic [15:0]          lastGap = '0;
    logic [15:0]          irqCnt = '0;
    int                   bad_count = 0;
    int                   checked = 0;

    ebt_timer u_ebt_timer (.*);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycN <= cycN + 16'h1;
        if (timerIrqFlag === 1'b1) begin
            lastGap <= cycN - lastIrq;
            lastIrq <= cycN;
            irqCnt  <= irqCnt + 16'h1;
        end
    end

    // ------------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic quiet(input int n);
        cyc(3);
        irqCnt = 16'h0;
        cyc(n);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        busAddr     <= a;
        busWrData   <= d;
        busWrStrobe <= 1'b1;
        @(posedge sys_clk);
        busWrStrobe <= 1'b0;
        #1;
    endtask

    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        checked++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            bad_count++;
        end
    endtask

    task automatic rc(input string n, input logic [ADDR_W-1:0] a,
                      input logic [7:0] e);
        busAddr     <= a;
        busRdStrobe <= 1'b1;
        @(posedge sys_clk);
        busRdStrobe <= 1'b0;
        #1;
        chk(n, 16'(busRdData), 16'(e));
    endtask

    task automatic complete_run();
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        rc("countLow", OFS_COUNT_LOW, 8'h00);
        rc("periodHigh", OFS_PERIOD_HIGH, 8'hff);
        rc("ctrlA", OFS_CTRL_A, 8'h00);
        rc("ctrlB", OFS_CTRL_B, 8'h00);
        rc("unmapped", 12'h1a0, 8'h00);
    endtask

    task automatic t_period8();
        wr(OFS_CTRL_B, {CS_INSTR, 1'b0, 4'h0});
        wr(OFS_PERIOD_HIGH, 8'h04);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_CTRL_A, 8'h80);
        cyc(30);
        chk("gap8", lastGap, 16'd5);
        wr(OFS_PERIOD_HIGH, 8'h09);
        cyc(40);
        chk("gapNew", lastGap, 16'd10);
    endtask

    task automatic t_post();
        for (int n = 0; n < 16; n++) begin
            wr(OFS_CTRL_A, 8'h80 | 8'(n));
            cyc(20 * (n + 1) + 12);
            chk("postGap", lastGap, 16'(10 * (n + 1)));
        end
    endtask

    task automatic t_pre();
        wr(OFS_PERIOD_HIGH, 8'h00);
        wr(OFS_CTRL_A, 8'h80);
        for (int n = 0; n < 16; n++) begin
            wr(OFS_CTRL_B, {CS_INSTR, 1'b0, 4'(n)});
            if (n < 13) begin
                cyc(2 * (1 << n) + 12);
                chk("preGap", lastGap, 16'(1 << n));
            end else begin
                quiet((1 << n) + 16);
                chk("preCnt", irqCnt, 16'd1);
            end
        end
    endtask

    task automatic t_clear();
        wr(OFS_CTRL_A, 8'h83);
        wr(OFS_CTRL_B, {CS_INSTR, 1'b0, 4'h0});
        irqCnt = 16'h0;
        repeat (20) begin
            wr(OFS_COUNT_LOW, 8'h00);
            cyc(1);
        end
        chk("postClr", irqCnt, 16'd0);
        cyc(20);
        chk("postRun", 16'(irqCnt != 0), 16'd1);
        wr(OFS_CTRL_A, 8'h80);
        wr(OFS_CTRL_B, {CS_INSTR, 1'b0, 4'h3});
        cyc(4);
        irqCnt = 16'h0;
        repeat (20) begin
            wr(OFS_CTRL_B, {CS_INSTR, 1'b0, 4'h3});
            cyc(1);
        end
        chk("preClr", irqCnt, 16'd0);
        cyc(30);
        chk("preRun", 16'(irqCnt != 0), 16'd1);
    endtask

    task automatic t_sleep();
        wr(OFS_PERIOD_HIGH, 8'h04);
        wr(OFS_CTRL_B, {CS_INSTR, 1'b0, 4'h0});
        sleepMode <= 1'b1;
        quiet(40);
        chk("syncSleep", irqCnt, 16'd0);
        wr(OFS_CTRL_B, {CS_INSTR, 1'b1, 4'h0});
        cyc(30);
        chk("asyncSleep", lastGap, 16'd5);
        sleepMode <= 1'b0;
    endtask

    task automatic t_src();
        wr(OFS_PERIOD_HIGH, 8'h00);
        for (int c = 0; c < 8; c++) begin
            if (c != 2) begin
                tmrPinIn  <= (c == 1);
                extSrcClk <= 5'h00;
                wr(OFS_CTRL_B, {3'(c), 1'b1, 4'h0});
                cyc(8);
                irqCnt = 16'h0;
                if (c < 3) begin
                    extSrcClk <= 5'h1f;
                end else begin
                    tmrPinIn  <= 1'b1;
                    extSrcClk <= ~(5'h01 << (c - 3));
                end
                cyc(10);
                chk("otherSrc", irqCnt, 16'd0);
                if (c < 2) begin
                    tmrPinIn <= (c == 0);
                end else begin
                    extSrcClk <= 5'h1f;
                end
                cyc(10);
                chk("selSrc", irqCnt, 16'd1);
            end
        end
    endtask

    task automatic t_wide16();
        wr(OFS_CTRL_A, 8'h10);
        wr(OFS_CTRL_B, {CS_INSTR, 1'b0, 4'h0});
        wr(OFS_PERIOD_HIGH, 8'hff);
        wr(OFS_COUNT_LOW, 8'hf0);
        wr(OFS_PERIOD_HIGH, 8'h00);
        rc("low16", OFS_COUNT_LOW, 8'hf0);
        rc("high16", OFS_PERIOD_HIGH, 8'hff);
        wr(OFS_CTRL_A, 8'h90);
        quiet(40);
        chk("wrap16", irqCnt, 16'd1);
        wr(OFS_CTRL_A, 8'h10);
        wr(OFS_PERIOD_HIGH, 8'h00);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_CTRL_B, {CS_INSTR, 1'b0, 4'hf});
        wr(OFS_CTRL_A, 8'h90);
        wr(OFS_PERIOD_HIGH, 8'h12);
        wr(OFS_COUNT_LOW, 8'h34);
        rc("lowRun", OFS_COUNT_LOW, 8'h00);
        rc("highRun", OFS_PERIOD_HIGH, 8'h00);
    endtask

    task automatic t_idle();
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_COUNT_LOW, 8'h20);
        rc("lowWrite", OFS_COUNT_LOW, 8'h20);
        quiet(50);
        rc("lowHeld", OFS_COUNT_LOW, 8'h20);
        chk("idleIrq", irqCnt, 16'd0);
    endtask

    initial begin
        nrst        = 1'b0;
        busAddr     = '0;
        busWrData   = '0;
        busWrStrobe = 1'b0;
        busRdStrobe = 1'b0;
        tmrPinIn    = 1'b0;
        extSrcClk   = '0;
        sleepMode   = 1'b0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        cyc(1);
        t_reset();
        t_period8();
        t_post();
        t_pre();
        t_clear();
        t_sleep();
        t_src();
        t_wide16();
        t_idle();
        nrst <= 1'b0;
        cyc(3);
        nrst <= 1'b1;
        cyc(1);
        rc("ctrlAAgain", OFS_CTRL_A, 8'h00);
        complete_run();
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end

endmodule // testbench

`default_nettype wire
